// ===== rtl/iirp_pkg.sv
/*
 * Shared constants and carrier types for the isolated input / relay port.
 * Assumes an 8-bit ISA-style I/O bus sampled synchronously on ref_clk_i.
 */
package iirp_pkg;
    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int IIRP_DATA_W = 8; // One byte port
    localparam int IIRP_ADDR_W = 10; // ISA I/O address bits used
    localparam logic [7:0] IIRP_RELAY_RST = 8'h00; // All relays off
    localparam logic [7:0] IIRP_IDLE_DATA = 8'hFF; // Read data after reset, until the first read
    // ------------------------------------------------------------------
    // Jumper-selectable base addresses, index 0 is the factory default
    // ------------------------------------------------------------------
    localparam int IIRP_NUM_BASES = 7; // Seven jumper choices
    localparam logic [9:0] IIRP_BASE_DEFAULT = 10'h300; // Factory base address
    localparam logic [9:0] IIRP_BASE_TBL [IIRP_NUM_BASES] = '{
        IIRP_BASE_DEFAULT, 10'h200, 10'h220, 10'h240, 10'h280, 10'h320, 10'h340
    };
    localparam logic [2:0] IIRP_SEL_DEFAULT = 3'h0; // Jumpers at factory setting

    // Host I/O cycle carrier
    typedef struct packed {
        logic [IIRP_ADDR_W-1:0] addr; // I/O address
        logic ior_n;                  // I/O read strobe, low active
        logic iow_n;                  // I/O write strobe, low active
        logic aen;                    // DMA address enable, high blocks decode
        logic [IIRP_DATA_W-1:0] wdata; // Write data from host
    } iirp_bus_s;
endpackage : iirp_pkg

// ===== rtl/iirp_port.sv
/*
 * Isolated input status / relay control byte port on an 8-bit I/O bus.
 * Assumes bus strobes and inputs are already synchronous to ref_clk_i;
 * the data pin tristate is resolved outside using data_oe_o.
 */
`timescale 1ns/10ps
module iirp_port (
    input wire logic ref_clk_i, // 250 MHz clock
    input wire logic rstn_i, // Async low reset (system reset)
    input wire logic clk_en_i, // Freezes all state while low
    input wire iirp_pkg::iirp_bus_s bus_i, // Host I/O cycle
    input wire logic [2:0] address_select_jumpers_i, // Base choice
    input wire logic [iirp_pkg::IIRP_DATA_W-1:0] input_status_bits_i, // Low = valid signal
    output logic [iirp_pkg::IIRP_DATA_W-1:0] rdata_o, // Read data to data pins
    output logic data_oe_o, // High while driving data pins
    output logic [iirp_pkg::IIRP_DATA_W-1:0] relay_control_bits_o // High = energised
);
    import iirp_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [IIRP_ADDR_W-1:0] base_addr; // Selected base
    logic hit; // Single byte match
    logic rd_hit; // Matching read cycle
    logic wr_hit; // Matching write cycle
    logic [IIRP_DATA_W-1:0] relay_ff; // Relay control register
    logic [IIRP_DATA_W-1:0] rdata_ff; // Read data flop
    logic oe_ff; // Data drive flop

    // Base from jumpers; unused code falls back to default
    always_comb begin
        if (address_select_jumpers_i < 3'(IIRP_NUM_BASES)) begin
            base_addr = IIRP_BASE_TBL[address_select_jumpers_i];
        end else begin
            base_addr = IIRP_BASE_TBL[IIRP_SEL_DEFAULT];
        end
    end

    // Full compare of all 10 bits, no aliases; 8-bit bus only
    assign hit = !bus_i.aen && (bus_i.addr == base_addr);
    assign rd_hit = hit && !bus_i.ior_n;
    assign wr_hit = hit && !bus_i.iow_n && bus_i.ior_n;

    // ------------------------------------------------------------------
    // Relay control register
    // ------------------------------------------------------------------
    // Reset clears all relays; whole byte replaced on write
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            relay_ff <= IIRP_RELAY_RST;
        end else if (clk_en_i && wr_hit) begin
            relay_ff <= bus_i.wdata;
        end
    end
    // Bit 0 de-energised, bit 1 energised, bit N to relay N
    assign relay_control_bits_o = relay_ff;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Input byte passed straight, inverted sense kept as wired
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= IIRP_IDLE_DATA;
            oe_ff <= 1'b0;
        end else if (clk_en_i) begin
            oe_ff <= rd_hit;
            if (rd_hit) begin
                rdata_ff <= input_status_bits_i;
            end
        end
    end
    assign rdata_o = rdata_ff;
    assign data_oe_o = oe_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Antecedents decode the bus fields directly where they can, so a
    // slip in the hit terms above shows up as a failing consequent.

    // Write to the selected byte taken at this edge
    sequence s_wr_take;
        clk_en_i && !bus_i.aen && bus_i.addr == base_addr && !bus_i.iow_n && bus_i.ior_n;
    endsequence

    // Read of the selected byte taken at this edge
    sequence s_rd_take;
        clk_en_i && !bus_i.aen && bus_i.addr == base_addr && !bus_i.ior_n;
    endsequence

    // Edge at which no write is taken
    sequence s_no_wr_take;
        !(clk_en_i && wr_hit);
    endsequence

    // Edge at which no read is taken
    sequence s_no_rd_take;
        !(clk_en_i && rd_hit);
    endsequence

    // Strobed cycle while the DMA enable owns the address lines
    sequence s_dma_cycle;
        clk_en_i && bus_i.aen && !(bus_i.ior_n && bus_i.iow_n);
    endsequence

    // Strobed cycle aimed at some other I/O address
    sequence s_foreign_cycle;
        clk_en_i && bus_i.addr != base_addr && !(bus_i.ior_n && bus_i.iow_n);
    endsequence

    // Edge at which the clock enable holds everything
    sequence s_frozen;
        !clk_en_i;
    endsequence

    // First edge after reset has been let go
    sequence s_rst_release;
        $rose(rstn_i);
    endsequence

    // Written byte reaches all relays one edge later
    property p_wr_load;
        logic [IIRP_DATA_W-1:0] d;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            (s_wr_take, d = bus_i.wdata) |=> relay_control_bits_o == d;
    endproperty

    // Relays move only on a taken write
    property p_relay_hold;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_no_wr_take |=> $stable(relay_control_bits_o);
    endproperty

    // Taken read drives the sampled input byte
    property p_rd_drive;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_rd_take |=> data_oe_o && rdata_o == $past(input_status_bits_i);
    endproperty

    // Read never loads the relays, even with both strobes low
    property p_rd_no_load;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_rd_take |=> $stable(relay_control_bits_o);
    endproperty

    // Write never turns the data drivers on
    property p_wr_no_drive;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_wr_take |=> !data_oe_o;
    endproperty

    // Drivers drop the cycle after any clock-enabled edge without a read
    property p_no_drive;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            (clk_en_i && !rd_hit) |=> !data_oe_o;
    endproperty

    // Read data holds between taken reads
    property p_rdata_hold;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_no_rd_take |=> $stable(rdata_o);
    endproperty

    // DMA cycles neither drive the bus nor touch the relays
    property p_dma_ignored;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_dma_cycle |=> !data_oe_o && $stable(relay_control_bits_o);
    endproperty

    // Cycles to other addresses are ignored the same way
    property p_foreign_ignored;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_foreign_cycle |=> !data_oe_o && $stable(relay_control_bits_o);
    endproperty

    // Factory jumper setting selects the default base
    property p_default_base;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            address_select_jumpers_i == IIRP_SEL_DEFAULT |-> base_addr == IIRP_BASE_DEFAULT;
    endproperty

    // Unused jumper codes fall back to the default base
    property p_spare_base;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            address_select_jumpers_i >= 3'(IIRP_NUM_BASES) |-> base_addr == IIRP_BASE_DEFAULT;
    endproperty

    // All outputs at their reset values right after release
    property p_rst_state;
        @(posedge ref_clk_i)
            s_rst_release |-> relay_control_bits_o == IIRP_RELAY_RST && !data_oe_o
                && rdata_o == IIRP_IDLE_DATA;
    endproperty

    // Low clock enable freezes every output
    property p_freeze;
        @(posedge ref_clk_i) disable iff (!rstn_i)
            s_frozen |=> $stable(relay_control_bits_o) && $stable(data_oe_o)
                && $stable(rdata_o);
    endproperty

    // Write path
    AST_WR_LOAD: assert property (p_wr_load)
        else $error("relay byte not loaded by write");
    AST_HOLD: assert property (p_relay_hold)
        else $error("relays changed without write");
    AST_WR_NO_DRIVE: assert property (p_wr_no_drive)
        else $error("write cycle drove the data bus");

    // Read path
    AST_RD_DRIVE: assert property (p_rd_drive)
        else $error("read data or drive wrong");
    AST_RD_NO_LOAD: assert property (p_rd_no_load)
        else $error("read cycle changed the relays");
    AST_NO_DRIVE: assert property (p_no_drive)
        else $error("drove bus off cycle");
    AST_RDATA_HOLD: assert property (p_rdata_hold)
        else $error("read data moved without read");

    // Decode
    AST_AEN: assert property (p_dma_ignored)
        else $error("cycle acted on during DMA");
    AST_FOREIGN: assert property (p_foreign_ignored)
        else $error("cycle to other address acted on");
    AST_DEFAULT: assert property (p_default_base)
        else $error("default base wrong");
    AST_SPARE_BASE: assert property (p_spare_base)
        else $error("spare jumper code not on default base");

    // Reset and clock enable
    AST_RST: assert property (p_rst_state)
        else $error("outputs not at reset values after reset");
    AST_FREEZE: assert property (p_freeze)
        else $error("state moved while frozen");
endmodule : iirp_port

// ===== tb/iirp_host.sv
/* Host model issuing single I/O cycles on the port's bus.
   Assumes the bench samples results at the falling edge after each cycle. */
`timescale 1ns/10ps
module iirp_host (
    input wire logic ref_clk_i, // Bus clock
    output iirp_pkg::iirp_bus_s bus_o // Host cycle
);
    import iirp_pkg::*;
    initial bus_o = '{10'h000, 1'b1, 1'b1, 1'b0, 8'h00};
    // One strobe cycle, then a released bus shows inverted leftovers
    task automatic cyc(input logic [9:0] a, input logic rd, input logic wr, input logic ae,
                       input logic [7:0] d);
        @(negedge ref_clk_i);
        bus_o = '{a, !rd, !wr, ae, d};
        @(negedge ref_clk_i);
        bus_o = '{~a, 1'b1, 1'b1, 1'b0, ~d};
    endtask : cyc
endmodule : iirp_host

// ===== tb/iirp_port_tb.sv
/* Self-checking bench for the input status / relay byte port.
   Assumes the host model drives all bus cycles. */
`timescale 1ns/10ps
module iirp_port_tb;
    import iirp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [7:0] ins = 8'hFF;
    logic [7:0] rdata, relays, shadow; // Shadow is the host's copy
    logic oe;
    logic [9:0] base;
    iirp_bus_s bus;
    int bad_count = 0;
    int num_checks = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    iirp_host u_host (.ref_clk_i(ref_clk_i), .bus_o(bus));
    iirp_port u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
        .bus_i(bus), .address_select_jumpers_i(sel), .input_status_bits_i(ins),
        .rdata_o(rdata), .data_oe_o(oe), .relay_control_bits_o(relays));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // Hang guard
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (16) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        chk(relays, 8'h00);
        for (int j = 0; j < 8; j++) begin
            sel = j[2:0];
            base = (j == 0 || j == 7) ? 10'h300 : IIRP_BASE_TBL[j];
            shadow = (8'h01 << j) ^ 8'h5A;
            u_host.cyc(base, 1'b0, 1'b1, 1'b0, shadow);
            chk(relays, shadow);
            u_host.cyc(base + 10'h001, 1'b0, 1'b1, 1'b0, ~shadow);
            chk(relays, shadow);
            u_host.cyc(base, 1'b0, 1'b1, 1'b1, ~shadow);
            chk(relays, shadow);
            ins = ~shadow;
            u_host.cyc(base, 1'b1, 1'b0, 1'b0, 8'h00);
            chk({7'h00, oe}, 8'h01);
            chk(rdata, ins);
            chk(relays, shadow);
            u_host.cyc(base ^ 10'h040, 1'b1, 1'b0, 1'b0, 8'h00);
            chk({7'h00, oe}, 8'h00);
        end
        clk_en_i = 1'b0;
        u_host.cyc(base, 1'b0, 1'b1, 1'b0, 8'hFF);
        chk(relays, shadow);
        clk_en_i = 1'b1;
        shadow = shadow | 8'h10;
        u_host.cyc(base, 1'b0, 1'b1, 1'b0, shadow);
        chk(relays, shadow);
        rstn_i = 1'b0;
        #1;
        chk(relays, 8'h00);
        @(negedge ref_clk_i);
        rstn_i = 1'b1;
        @(negedge ref_clk_i);
        chk(relays, 8'h00);
        chk({7'h00, oe}, 8'h00);
        final_report();
    end
endmodule : iirp_port_tb
